/* logic/ats_aux_test_mux.sv */
`timescale 1ns/1ps

module ats_aux_test_mux (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire ats_pkg::ats_reg_req_t reg_req_i,
  output logic [7:0]                 reg_rdata_o,
  input  wire ats_pkg::ats_analog_t  analog_i,
  input  wire ats_pkg::ats_activity_t activity_i,
  input  wire logic                  smclk_i,
  input  wire logic [7:0]            test_bus_i,
  input  wire logic [2:0]            test_bus_bit_selector_i,
  input  wire logic [3:0]            adc_i_sample_i,
  input  wire logic [3:0]            adc_q_sample_i,
  output ats_pkg::ats_pin_t          first_auxiliary_pin_o,
  output ats_pkg::ats_pin_t          second_auxiliary_pin_o
);
  import ats_pkg::*;

  logic [7:0] aux_output_source_select_ff;
  logic [5:0] first_dac_value_ff;
  logic       first_dac_rft_ff;
  logic [5:0] second_dac_value_ff;
  logic [7:0] ptest_a_ff;
  logic [7:0] ptest_b_ff;
  logic [7:0] ptest_c_ff;
  logic [7:0] ptest_d_ff;
  logic [7:0] nxt_rdata;
  logic [3:0] first_pin_source_field;
  logic [3:0] second_pin_source_field;
  logic       test_bus_bit;
  ats_pin_t   nxt_pin1;
  ats_pin_t   nxt_pin2;
  logic       wr_sel;
  logic       wr_dac1;
  logic       wr_dac2;

  assign first_pin_source_field  = aux_output_source_select_ff[SEL1_HI:SEL1_LO];
  assign second_pin_source_field = aux_output_source_select_ff[SEL2_HI:SEL2_LO];
  assign test_bus_bit = test_bus_i[test_bus_bit_selector_i];

  assign wr_sel  = reg_req_i.wr && (reg_req_i.addr == ADDR_AUX_SEL);
  assign wr_dac1 = reg_req_i.wr && (reg_req_i.addr == ADDR_DAC1);
  assign wr_dac2 = reg_req_i.wr && (reg_req_i.addr == ADDR_DAC2);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_output_source_select_ff <= RST_AUX_SEL;
    end else if (wr_sel) begin
      aux_output_source_select_ff <= reg_req_i.wdata;
    end
  end

  // Converter values have no documented reset; cleared anyway for a known start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_dac_value_ff  <= RST_DAC;
      first_dac_rft_ff    <= RST_DAC1_RFT;
      second_dac_value_ff <= RST_DAC;
    end else begin
      if (wr_dac1) begin
        first_dac_value_ff <= reg_req_i.wdata[DAC_HI:0];
        first_dac_rft_ff   <= reg_req_i.wdata[DAC1_RFT_BIT];
      end
      if (wr_dac2) begin
        second_dac_value_ff <= reg_req_i.wdata[DAC_HI:0];
      end
    end
  end

  // Production test registers keep their writes but steer nothing here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptest_a_ff <= RST_PTEST_A;
      ptest_b_ff <= RST_PTEST_B;
      ptest_c_ff <= RST_PTEST_C;
      ptest_d_ff <= RST_PTEST_D;
    end else if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        ADDR_PTEST_A: ptest_a_ff <= reg_req_i.wdata;
        ADDR_PTEST_B: ptest_b_ff <= reg_req_i.wdata;
        ADDR_PTEST_C: ptest_c_ff <= reg_req_i.wdata;
        ADDR_PTEST_D: ptest_d_ff <= reg_req_i.wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (reg_req_i.addr)
      ADDR_AUX_SEL: nxt_rdata = aux_output_source_select_ff;
      ADDR_DAC1:    nxt_rdata = {first_dac_rft_ff, 1'b0, first_dac_value_ff};
      ADDR_DAC2:    nxt_rdata = {2'b00, second_dac_value_ff};
      ADDR_ADC:     nxt_rdata = {adc_i_sample_i, adc_q_sample_i};
      ADDR_PTEST_A: nxt_rdata = ptest_a_ff;
      ADDR_PTEST_B: nxt_rdata = ptest_b_ff;
      ADDR_PTEST_C: nxt_rdata = ptest_c_ff;
      ADDR_PTEST_D: nxt_rdata = ptest_d_ff;
      default:      nxt_rdata = 8'h00;
    endcase
  end

  // Read data registered: ADC sample is the one present on the read cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_req_i.rd) begin
      reg_rdata_o <= nxt_rdata;
    end
  end

  function automatic ats_pin_t pin_mux(input logic [3:0] sel, input logic [5:0] dac);
    ats_pin_t p;
    p = '0;
    p.oe = 1'b1;
    case (sel)
      SRC_TRISTATE: p.oe = 1'b0;
      SRC_DAC: begin
        p.dac_en  = 1'b1;
        p.dac_val = dac;
      end
      SRC_FIRST_CORR:  p.dout = analog_i.first_correlator_signal;
      SRC_SECOND_CORR: p.dout = analog_i.second_correlator_signal;
      SRC_MINLVL: p.dout = analog_i.minlvl;
      SRC_ADC_I:  p.dout = analog_i.adc_i;
      SRC_ADC_Q:  p.dout = analog_i.adc_q;
      SRC_ADC_IQ: p.dout = analog_i.adc_iq;
      SRC_PROD:   p.dout = analog_i.prod;
      SRC_SMCLK:  p.dout = smclk_i;
      SRC_HIGH:   p.dout = 1'b1;
      SRC_LOW:    p.dout = 1'b0;
      SRC_TX_ACT: p.dout = activity_i.tx_act;
      SRC_RX_ACT: p.dout = activity_i.rx_act;
      SRC_SUBC:   p.dout = activity_i.subc;
      SRC_TBUS:   p.dout = test_bus_bit;
      default:    p.oe = 1'b0;
    endcase
    return p;
  endfunction

  // Sources are already core-clocked; the sampled clock is a test view only
  assign nxt_pin1 = pin_mux(first_pin_source_field, first_dac_value_ff);
  assign nxt_pin2 = pin_mux(second_pin_source_field, second_dac_value_ff);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_auxiliary_pin_o  <= '0;
      second_auxiliary_pin_o <= '0;
    end else begin
      first_auxiliary_pin_o  <= nxt_pin1;
      second_auxiliary_pin_o <= nxt_pin2;
    end
  end

  property p_sel_reset;
    @(posedge clk_i) $past(rst_i) |-> aux_output_source_select_ff == RST_AUX_SEL;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("select not cleared by reset");

  property p_sel_write;
    @(posedge clk_i) disable iff (rst_i) wr_sel |=> aux_output_source_select_ff == $past(reg_req_i.wdata);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select write lost");

  property p_tristate1;
    @(posedge clk_i) disable iff (rst_i)
      first_pin_source_field == SRC_TRISTATE |=> !first_auxiliary_pin_o.oe;
  endproperty
  a_tristate1: assert property (p_tristate1) else $error("pin1 driven in tristate");

  property p_high2;
    @(posedge clk_i) disable iff (rst_i)
      second_pin_source_field == SRC_HIGH |=> second_auxiliary_pin_o.oe && second_auxiliary_pin_o.dout;
  endproperty
  a_high2: assert property (p_high2) else $error("pin2 not high");

  property p_dac1_only;
    @(posedge clk_i) disable iff (rst_i)
      first_auxiliary_pin_o.dac_en |-> $past(first_pin_source_field) == SRC_DAC
        && first_auxiliary_pin_o.dac_val == $past(first_dac_value_ff);
  endproperty
  a_dac1_only: assert property (p_dac1_only) else $error("dac1 on pin1 wrongly");

  property p_dac2_only;
    @(posedge clk_i) disable iff (rst_i)
      second_auxiliary_pin_o.dac_en |-> $past(second_pin_source_field) == SRC_DAC
        && second_auxiliary_pin_o.dac_val == $past(second_dac_value_ff);
  endproperty
  a_dac2_only: assert property (p_dac2_only) else $error("dac2 on pin2 wrongly");

  property p_tx1;
    @(posedge clk_i) disable iff (rst_i)
      first_pin_source_field == SRC_TX_ACT |=> first_auxiliary_pin_o.dout == $past(activity_i.tx_act);
  endproperty
  a_tx1: assert property (p_tx1) else $error("tx strobe not routed");

  property p_adc_read;
    @(posedge clk_i) disable iff (rst_i)
      reg_req_i.rd && reg_req_i.addr == ADDR_ADC
        |=> reg_rdata_o == {$past(adc_i_sample_i), $past(adc_q_sample_i)};
  endproperty
  a_adc_read: assert property (p_adc_read) else $error("adc readback wrong");

  property p_dac2_resv;
    @(posedge clk_i) disable iff (rst_i)
      reg_req_i.rd && reg_req_i.addr == ADDR_DAC2 |=> reg_rdata_o[7:6] == 2'b00;
  endproperty
  a_dac2_resv: assert property (p_dac2_resv) else $error("dac2 reserved bits set");

  property p_ptest_reset;
    @(posedge clk_i) $past(rst_i) |-> ptest_a_ff == RST_PTEST_A && ptest_c_ff == RST_PTEST_C
      && ptest_b_ff == RST_PTEST_B && ptest_d_ff == RST_PTEST_D;
  endproperty
  a_ptest_reset: assert property (p_ptest_reset) else $error("production reset wrong");

  // Named steps shared by the write and readback checks
  sequence s_wr_dac1;
    wr_dac1;
  endsequence

  sequence s_rd_dac1;
    reg_req_i.rd && reg_req_i.addr == ADDR_DAC1;
  endsequence

  sequence s_rd_adc;
    reg_req_i.rd && reg_req_i.addr == ADDR_ADC;
  endsequence

  // Select write, then field update, then pin register: two edges in all
  sequence s_sel_high1;
    wr_sel && reg_req_i.wdata[SEL1_HI:SEL1_LO] == SRC_HIGH;
  endsequence

  property p_sel_hold;
    @(posedge clk_i) disable iff (rst_i) !wr_sel |=> $stable(aux_output_source_select_ff);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select changed unasked");

  property p_sel_to_pin;
    @(posedge clk_i) disable iff (rst_i)
      s_sel_high1 |-> ##2 (first_auxiliary_pin_o.oe && first_auxiliary_pin_o.dout);
  endproperty
  a_sel_to_pin: assert property (p_sel_to_pin) else $error("pin1 high missing");

  property p_tristate2;
    @(posedge clk_i) disable iff (rst_i)
      second_pin_source_field == SRC_TRISTATE |=> !second_auxiliary_pin_o.oe;
  endproperty
  a_tristate2: assert property (p_tristate2) else $error("pin2 driven in tristate");

  property p_low2;
    @(posedge clk_i) disable iff (rst_i)
      second_pin_source_field == SRC_LOW |=> second_auxiliary_pin_o.oe && !second_auxiliary_pin_o.dout;
  endproperty
  a_low2: assert property (p_low2) else $error("pin2 not low");

  property p_dac1_route;
    @(posedge clk_i) disable iff (rst_i)
      first_pin_source_field == SRC_DAC |=> first_auxiliary_pin_o.dac_en;
  endproperty
  a_dac1_route: assert property (p_dac1_route) else $error("dac1 not routed");

  property p_dac2_route;
    @(posedge clk_i) disable iff (rst_i)
      second_pin_source_field == SRC_DAC |=> second_auxiliary_pin_o.dac_en;
  endproperty
  a_dac2_route: assert property (p_dac2_route) else $error("dac2 not routed");

  property p_corr_route1;
    @(posedge clk_i) disable iff (rst_i) first_pin_source_field == SRC_FIRST_CORR
      |=> first_auxiliary_pin_o.dout == $past(analog_i.first_correlator_signal);
  endproperty
  a_corr_route1: assert property (p_corr_route1) else $error("correlator not routed");

  property p_smclk1;
    @(posedge clk_i) disable iff (rst_i)
      first_pin_source_field == SRC_SMCLK |=> first_auxiliary_pin_o.dout == $past(smclk_i);
  endproperty
  a_smclk1: assert property (p_smclk1) else $error("module clock not routed");

  property p_rx2;
    @(posedge clk_i) disable iff (rst_i) second_pin_source_field == SRC_RX_ACT
      |=> second_auxiliary_pin_o.dout == $past(activity_i.rx_act);
  endproperty
  a_rx2: assert property (p_rx2) else $error("rx strobe not routed");

  property p_subc1;
    @(posedge clk_i) disable iff (rst_i) first_pin_source_field == SRC_SUBC
      |=> first_auxiliary_pin_o.dout == $past(activity_i.subc);
  endproperty
  a_subc1: assert property (p_subc1) else $error("subcarrier flag not routed");

  property p_tbus2;
    @(posedge clk_i) disable iff (rst_i)
      second_pin_source_field == SRC_TBUS |=> second_auxiliary_pin_o.dout == $past(test_bus_bit);
  endproperty
  a_tbus2: assert property (p_tbus2) else $error("test bus bit not routed");

  property p_dac1_write;
    @(posedge clk_i) disable iff (rst_i)
      s_wr_dac1 |=> first_dac_value_ff == $past(reg_req_i.wdata[DAC_HI:0])
        && first_dac_rft_ff == $past(reg_req_i.wdata[DAC1_RFT_BIT]);
  endproperty
  a_dac1_write: assert property (p_dac1_write) else $error("dac1 write lost");

  property p_dac1_read;
    @(posedge clk_i) disable iff (rst_i)
      s_rd_dac1 |=> reg_rdata_o == {$past(first_dac_rft_ff), 1'b0, $past(first_dac_value_ff)};
  endproperty
  a_dac1_read: assert property (p_dac1_read) else $error("dac1 readback wrong");

  property p_adc_q;
    @(posedge clk_i) disable iff (rst_i)
      s_rd_adc |=> reg_rdata_o[3:0] == $past(adc_q_sample_i);
  endproperty
  a_adc_q: assert property (p_adc_q) else $error("q sample readback wrong");

  property p_dac_rest1;
    @(posedge clk_i) disable iff (rst_i)
      first_pin_source_field != SRC_DAC |=> !first_auxiliary_pin_o.dac_en;
  endproperty
  a_dac_rest1: assert property (p_dac_rest1) else $error("dac1 on pin1 off code");

  property p_dac_rest2;
    @(posedge clk_i) disable iff (rst_i)
      second_pin_source_field != SRC_DAC |=> !second_auxiliary_pin_o.dac_en;
  endproperty
  a_dac_rest2: assert property (p_dac_rest2) else $error("dac2 on pin2 off code");

  property p_ptest_bd_reset;
    @(posedge clk_i)
      $past(rst_i) |-> ptest_b_ff == RST_PTEST_B && ptest_d_ff == RST_PTEST_D;
  endproperty
  a_ptest_bd_reset: assert property (p_ptest_bd_reset) else $error("production b d reset");

  property p_ptest_c_reset;
    @(posedge clk_i) $past(rst_i) |-> ptest_c_ff == RST_PTEST_C;
  endproperty
  a_ptest_c_reset: assert property (p_ptest_c_reset) else $error("production c reset");

endmodule // ats_aux_test_mux

/* logic/ats_pkg.sv */
package ats_pkg;

  // Register map offsets (6-bit register address space)
  localparam logic [5:0] ADDR_AUX_SEL   = 6'h38;
  localparam logic [5:0] ADDR_DAC1      = 6'h39;
  localparam logic [5:0] ADDR_DAC2      = 6'h3A;
  localparam logic [5:0] ADDR_ADC       = 6'h3B;
  localparam logic [5:0] ADDR_PTEST_A   = 6'h3C;
  localparam logic [5:0] ADDR_PTEST_B   = 6'h3D;
  localparam logic [5:0] ADDR_PTEST_C   = 6'h3E;
  localparam logic [5:0] ADDR_PTEST_D   = 6'h3F;

  // Reset values
  localparam logic [7:0] RST_AUX_SEL    = 8'h00;
  localparam logic [5:0] RST_DAC        = 6'h00;
  localparam logic       RST_DAC1_RFT   = 1'h0;
  localparam logic [7:0] RST_PTEST_A    = 8'hFF;
  localparam logic [7:0] RST_PTEST_B    = 8'h00;
  localparam logic [7:0] RST_PTEST_C    = 8'h03;
  localparam logic [7:0] RST_PTEST_D    = 8'h00;

  // Field positions
  localparam int SEL1_HI = 7;
  localparam int SEL1_LO = 4;
  localparam int SEL2_HI = 3;
  localparam int SEL2_LO = 0;
  localparam int DAC_HI  = 5;
  localparam int DAC1_RFT_BIT = 7;

  // Source codes of one auxiliary pin
  localparam logic [3:0] SRC_TRISTATE = 4'h0;
  localparam logic [3:0] SRC_DAC      = 4'h1;
  localparam logic [3:0] SRC_FIRST_CORR  = 4'h2;
  localparam logic [3:0] SRC_SECOND_CORR = 4'h3;
  localparam logic [3:0] SRC_MINLVL   = 4'h4;
  localparam logic [3:0] SRC_ADC_I    = 4'h5;
  localparam logic [3:0] SRC_ADC_Q    = 4'h6;
  localparam logic [3:0] SRC_ADC_IQ   = 4'h7;
  localparam logic [3:0] SRC_PROD     = 4'h8;
  localparam logic [3:0] SRC_SMCLK    = 4'h9;
  localparam logic [3:0] SRC_HIGH     = 4'hA;
  localparam logic [3:0] SRC_LOW      = 4'hB;
  localparam logic [3:0] SRC_TX_ACT   = 4'hC;
  localparam logic [3:0] SRC_RX_ACT   = 4'hD;
  localparam logic [3:0] SRC_SUBC     = 4'hE;
  localparam logic [3:0] SRC_TBUS     = 4'hF;

  // Register write and read request port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } ats_reg_req_t;

  // Digital view of the analog test sources shared by both pins
  typedef struct packed {
    logic first_correlator_signal;
    logic second_correlator_signal;
    logic minlvl;
    logic adc_i;
    logic adc_q;
    logic adc_iq;
    logic prod;
  } ats_analog_t;

  // Receiver and transmitter activity sources
  typedef struct packed {
    logic tx_act;
    logic rx_act;
    logic subc;
  } ats_activity_t;

  // One driven auxiliary pin
  typedef struct packed {
    logic       oe;
    logic       dout;
    logic       dac_en;
    logic [5:0] dac_val;
  } ats_pin_t;

endpackage

/* testbench/aux_test_signal_mux_bench.sv */
`timescale 1ns/1ps

module aux_test_signal_mux_bench;
  import ats_pkg::*;

  logic          clk;
  logic          rst;
  ats_reg_req_t  req;
  logic [7:0]    rdata;
  ats_analog_t   analog;
  ats_activity_t activity;
  logic          smclk;
  logic [7:0]    tbus;
  logic [2:0]    tsel;
  logic [3:0]    adc_i;
  logic [3:0]    adc_q;
  ats_pin_t      pin1;
  ats_pin_t      pin2;
  int            miscompares;
  int            checks;
  int            seed;
  logic [31:0]   r;
  logic [5:0]    dac1_v;
  logic [5:0]    dac2_v;
  logic [7:0]    rst_exp [8];

  ats_aux_test_mux i_dut (
    .clk_i                   (clk),
    .rst_i                   (rst),
    .reg_req_i               (req),
    .reg_rdata_o             (rdata),
    .analog_i                (analog),
    .activity_i              (activity),
    .smclk_i                 (smclk),
    .test_bus_i              (tbus),
    .test_bus_bit_selector_i (tsel),
    .adc_i_sample_i          (adc_i),
    .adc_q_sample_i          (adc_q),
    .first_auxiliary_pin_o   (pin1),
    .second_auxiliary_pin_o  (pin2)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic report_and_stop();
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: the run is short, so anything past this bound is a hang
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("Error at %0t: run did not finish", $time);
    report_and_stop();
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  function automatic logic src_val(input logic [3:0] c);
    case (c)
      SRC_FIRST_CORR:  return analog.first_correlator_signal;
      SRC_SECOND_CORR: return analog.second_correlator_signal;
      SRC_MINLVL: return analog.minlvl;
      SRC_ADC_I:  return analog.adc_i;
      SRC_ADC_Q:  return analog.adc_q;
      SRC_ADC_IQ: return analog.adc_iq;
      SRC_PROD:   return analog.prod;
      SRC_SMCLK:  return smclk;
      SRC_HIGH:   return 1'b1;
      SRC_TX_ACT: return activity.tx_act;
      SRC_RX_ACT: return activity.rx_act;
      SRC_SUBC:   return activity.subc;
      SRC_TBUS:   return tbus[tsel];
      default:    return 1'b0;
    endcase
  endfunction

  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  // Read data is registered, so it is looked at one cycle after the strobe
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req.rd = 1'b0;
    chk_byte(rdata, exp);
  endtask

  task automatic rand_src();
    r = $random(seed);
    {analog, activity, smclk, tbus, tsel, adc_i, adc_q} = r[29:0];
  endtask

  task automatic chk_pin(input ats_pin_t p, input logic [3:0] c, input logic [5:0] dv);
    if (c == SRC_TRISTATE) begin
      chk_bit(p.oe, 1'b0);
    end else if (c == SRC_DAC) begin
      chk_bit(p.dac_en, 1'b1);
      chk_byte({2'b00, p.dac_val}, {2'b00, dv});
    end else begin
      chk_bit(p.oe, 1'b1);
      chk_bit(p.dout, src_val(c));
      chk_bit(p.dac_en, 1'b0);
    end
  endtask

  initial begin
    miscompares = 0;
    checks = 0;
    seed = 47;
    rst = 1'b1;
    req = '0;
    {analog, activity, smclk, tbus, tsel, adc_i, adc_q} = '0;
    rst_exp = '{RST_AUX_SEL, 8'h00, 8'h00, 8'h00,
                RST_PTEST_A, RST_PTEST_B, RST_PTEST_C, RST_PTEST_D};
    do_reset();
    chk_bit(pin1.oe, 1'b0);
    chk_bit(pin2.oe, 1'b0);
    for (int i = 0; i < 8; i++) begin
      rd_chk(ADDR_AUX_SEL + 6'(i), rst_exp[i]);
    end
    rd_chk(6'h00, 8'h00);
    repeat (6) begin
      r = $random(seed);
      dac1_v = r[5:0];
      dac2_v = r[13:8];
      wr_reg(ADDR_DAC1, {2'b11, dac1_v});
      wr_reg(ADDR_DAC2, {2'b11, dac2_v});
      wr_reg(ADDR_ADC, r[23:16]);
      rd_chk(ADDR_DAC1, {2'b10, dac1_v});
      rd_chk(ADDR_DAC2, {2'b00, dac2_v});
      rand_src();
      rd_chk(ADDR_ADC, {adc_i, adc_q});
    end
    wr_reg(ADDR_DAC1, 8'h3F);
    wr_reg(ADDR_DAC2, 8'h15);
    for (int c = 0; c < 16; c++) begin
      wr_reg(ADDR_AUX_SEL, {4'(c), ~4'(c)});
      rd_chk(ADDR_AUX_SEL, {4'(c), ~4'(c)});
      repeat (4) begin
        rand_src();
        @(negedge clk);
        chk_pin(pin1, 4'(c), 6'h3F);
        chk_pin(pin2, ~4'(c), 6'h15);
      end
    end
    do_reset();
    rd_chk(ADDR_AUX_SEL, RST_AUX_SEL);
    chk_bit(pin1.oe, 1'b0);
    report_and_stop();
  end

endmodule // aux_test_signal_mux_bench
